// file: design/dtc_defs.svh
// Register indices, field positions, reset values and counts of the timer
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// Register indices; byte address is four times the index
`define DTC_IDX_CONTROL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_LOW_ZERO 8'h8A
`define DTC_IDX_LOW_ONE 8'h8B
`define DTC_IDX_HIGH_ZERO 8'h8C
`define DTC_IDX_HIGH_ONE 8'h8D

// Control register fields
`define DTC_CTL_FLAG_ONE 7
`define DTC_CTL_RUN_ONE 6
`define DTC_CTL_FLAG_ZERO 5
`define DTC_CTL_RUN_ZERO 4

// Mode register fields, per nibble
`define DTC_MOD_GATE 3
`define DTC_MOD_CT 2
`define DTC_MOD_HIGH 1
`define DTC_MOD_LOW 0

// Reset values
`define DTC_RST_CONTROL 8'h00
`define DTC_RST_MODE 8'h00
`define DTC_RST_COUNT 8'h00

// Clocks per machine cycle
`define DTC_MC_CLOCKS 12

`endif

// file: design/dtc_pkg.sv
// Types shared by the dual timer/counter
package dtc_pkg;

    // Counter mode field
    typedef enum logic [1:0] {
        DTC_MODE_13 = 2'b00,
        DTC_MODE_16 = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_type;

    // One nibble of the mode register
    typedef struct packed {
        logic gate;
        logic ct;
        dtc_mode_type mode;
    } dtc_cfg_type;

    // Result of one counting step
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic ovf;
    } dtc_step_type;

endpackage

// file: design/dtc_timer.sv
// Dual 16-bit timer/counter with a classic Wishbone register slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`include "dtc_defs.svh"

module dtc_timer
    import dtc_pkg::*;
#(
    parameter int ADR_W = 12,
    parameter int MC_CLOCKS = `DTC_MC_CLOCKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic count_input_zero,
    input wire logic count_input_one,
    input wire logic external_gate_pin_zero,
    input wire logic external_gate_pin_one,
    input wire logic int_serviced_zero,
    input wire logic int_serviced_one,
    output logic overflow_flag_zero,
    output logic overflow_flag_one,
    output logic baud_tick
);

    // ****************************************************************
    // Counting step shared by both timers
    // ****************************************************************

    // Advance a timer by one count in the given mode
    function automatic dtc_step_type dtc_step(
        input dtc_mode_type mode,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        dtc_step_type s;
        logic [5:0] l5;
        logic [8:0] l9;
        logic [8:0] h9;
        s.lo = lo;
        s.hi = hi;
        s.ovf = 1'b0;
        l5 = {1'b0, lo[4:0]} + 6'h01;
        l9 = {1'b0, lo} + 9'h001;
        h9 = {1'b0, hi} + 9'h001;
        unique case (mode)
            DTC_MODE_13: begin
                // Low five bits act as a divide-by-32 prescaler
                s.lo = {lo[7:5], l5[4:0]};
                if (l5[5]) begin
                    s.hi = h9[7:0];
                    s.ovf = h9[8];
                end
            end
            DTC_MODE_16: begin
                // Full sixteen bits count
                s.lo = l9[7:0];
                if (l9[8]) begin
                    s.hi = h9[7:0];
                    s.ovf = h9[8];
                end
            end
            DTC_MODE_RELOAD: begin
                // Low byte reloads from the untouched high byte
                s.lo = l9[8] ? hi : l9[7:0];
                s.ovf = l9[8];
            end
            DTC_MODE_SPLIT: begin
                // Low byte alone as an 8-bit counter
                s.lo = l9[7:0];
                s.ovf = l9[8];
            end
        endcase
        return s;
    endfunction

    // ****************************************************************
    // Register state
    // ****************************************************************

    logic [7:0] mode_q;
    logic run_bit_zero_q;
    logic run_bit_one_q;
    logic [7:0] count_low_zero_q;
    logic [7:0] count_high_zero_q;
    logic [7:0] count_low_one_q;
    logic [7:0] count_high_one_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic baud_q;

    dtc_cfg_type cfg_zero;
    dtc_cfg_type cfg_one;
    assign cfg_zero = dtc_cfg_type'(mode_q[3:0]);
    assign cfg_one = dtc_cfg_type'(mode_q[7:4]);

    // ****************************************************************
    // Wishbone slave decode
    // ****************************************************************

    logic [7:0] idx;
    logic req;
    logic wr;
    logic [7:0] wbyte;
    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i & wb_stb_i;
    // Writes land on the edge at which the master sees ack
    assign wr = req & wb_we_i & ack_q & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    logic wr_ctl;
    logic wr_mode;
    logic wr_lo0;
    logic wr_hi0;
    logic wr_lo1;
    logic wr_hi1;
    assign wr_ctl = wr & (idx == `DTC_IDX_CONTROL);
    assign wr_mode = wr & (idx == `DTC_IDX_MODE);
    assign wr_lo0 = wr & (idx == `DTC_IDX_LOW_ZERO);
    assign wr_hi0 = wr & (idx == `DTC_IDX_HIGH_ZERO);
    assign wr_lo1 = wr & (idx == `DTC_IDX_LOW_ONE);
    assign wr_hi1 = wr & (idx == `DTC_IDX_HIGH_ONE);

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data captured with the request; unmapped reads give zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (req & ~ack_q) begin
            rdata_q <= 32'h0000_0000;
            unique case (idx)
                `DTC_IDX_CONTROL: begin
                    rdata_q[`DTC_CTL_FLAG_ONE] <= overflow_flag_one;
                    rdata_q[`DTC_CTL_RUN_ONE] <= run_bit_one_q;
                    rdata_q[`DTC_CTL_FLAG_ZERO] <= overflow_flag_zero;
                    rdata_q[`DTC_CTL_RUN_ZERO] <= run_bit_zero_q;
                end
                `DTC_IDX_MODE: begin
                    rdata_q[7:0] <= mode_q;
                end
                `DTC_IDX_LOW_ZERO: begin
                    rdata_q[7:0] <= count_low_zero_q;
                end
                `DTC_IDX_HIGH_ZERO: begin
                    rdata_q[7:0] <= count_high_zero_q;
                end
                `DTC_IDX_LOW_ONE: begin
                    rdata_q[7:0] <= count_low_one_q;
                end
                `DTC_IDX_HIGH_ONE: begin
                    rdata_q[7:0] <= count_high_one_q;
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Mode register, plain read/write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= `DTC_RST_MODE;
        end else if (wr_mode) begin
            mode_q <= wbyte;
        end
    end

    // Run bits live in the control register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_bit_zero_q <= 1'b0;
            run_bit_one_q <= 1'b0;
        end else if (wr_ctl) begin
            run_bit_zero_q <= wbyte[`DTC_CTL_RUN_ZERO];
            run_bit_one_q <= wbyte[`DTC_CTL_RUN_ONE];
        end
    end

    // ****************************************************************
    // Machine cycle prescaler
    // ****************************************************************

    localparam int MC_W = $clog2(MC_CLOCKS);
    localparam logic [MC_W-1:0] MC_LAST = MC_W'(MC_CLOCKS - 1);
    logic [MC_W-1:0] mc_cnt_q;
    logic mc_tick;

    // One tick every MC_CLOCKS clocks, twelve by default
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mc_cnt_q <= '0;
        end else if (mc_cnt_q == MC_LAST) begin
            mc_cnt_q <= '0;
        end else begin
            mc_cnt_q <= mc_cnt_q + MC_W'(1);
        end
    end
    assign mc_tick = (mc_cnt_q == MC_LAST);

    // ****************************************************************
    // Input synchronisers and falling-edge detection
    // ****************************************************************

    // Bits 0/1 count inputs, bits 2/3 gate inputs
    logic [3:0] pins;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] samp_q;
    logic [3:0] fall_q;
    assign pins = {external_gate_pin_one, external_gate_pin_zero,
                   count_input_one, count_input_zero};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_in
            // Two-flop synchroniser per pin
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pins[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
            // Sample once per machine cycle; one-cycle fall pulse
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    samp_q[gi] <= 1'b0;
                    fall_q[gi] <= 1'b0;
                end else if (mc_tick) begin
                    samp_q[gi] <= sync2_q[gi];
                    fall_q[gi] <= samp_q[gi] & ~sync2_q[gi];
                end else begin
                    fall_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Count enables
    // ****************************************************************

    logic split0;
    logic stop1;
    logic open0;
    logic open1;
    logic src0;
    logic src1;
    logic inc0;
    logic inc0h;
    logic inc1;
    assign split0 = (cfg_zero.mode == DTC_MODE_SPLIT);
    assign stop1 = (cfg_one.mode == DTC_MODE_SPLIT);

    // Gate condition: gate clear or gate input high
    assign open0 = ~cfg_zero.gate | sync2_q[2];
    assign open1 = ~cfg_one.gate | sync2_q[3];

    // Source: input edges or machine cycles
    assign src0 = cfg_zero.ct ? fall_q[0] : mc_tick;
    assign src1 = cfg_one.ct ? fall_q[1] : mc_tick;

    assign inc0 = run_bit_zero_q & open0 & src0;
    // Split high byte counts machine cycles under run bit one
    assign inc0h = split0 & run_bit_one_q & mc_tick;
    // Timer 1 loses its run bit to the split high byte
    assign inc1 = ~stop1 & open1 & src1 &
                  (split0 | run_bit_one_q);

    dtc_step_type step0;
    dtc_step_type step1;
    logic [8:0] hi0_sum;
    assign step0 = dtc_step(cfg_zero.mode, count_low_zero_q,
                            count_high_zero_q);
    assign step1 = dtc_step(cfg_one.mode, count_low_one_q,
                            count_high_one_q);
    assign hi0_sum = {1'b0, count_high_zero_q} + 9'h001;

    logic set0;
    logic set1;
    logic ovf1;
    assign ovf1 = inc1 & step1.ovf;
    assign set0 = inc0 & step0.ovf;
    assign set1 = split0 ? (inc0h & hi0_sum[8]) : ovf1;

    // ****************************************************************
    // Count registers
    // ****************************************************************

    // Timer 0 low byte: software write wins over a count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_low_zero_q <= `DTC_RST_COUNT;
        end else if (wr_lo0) begin
            count_low_zero_q <= wbyte;
        end else if (inc0) begin
            count_low_zero_q <= step0.lo;
        end
    end

    // Timer 0 high byte: carry, or own counter when split
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_high_zero_q <= `DTC_RST_COUNT;
        end else if (wr_hi0) begin
            count_high_zero_q <= wbyte;
        end else if (split0) begin
            if (inc0h) begin
                count_high_zero_q <= hi0_sum[7:0];
            end
        end else if (inc0) begin
            count_high_zero_q <= step0.hi;
        end
    end

    // Timer 1 low byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_low_one_q <= `DTC_RST_COUNT;
        end else if (wr_lo1) begin
            count_low_one_q <= wbyte;
        end else if (inc1) begin
            count_low_one_q <= step1.lo;
        end
    end

    // Timer 1 high byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_high_one_q <= `DTC_RST_COUNT;
        end else if (wr_hi1) begin
            count_high_one_q <= wbyte;
        end else if (inc1) begin
            count_high_one_q <= step1.hi;
        end
    end

    // ****************************************************************
    // Overflow flags and baud tick
    // ****************************************************************

    // Hardware set wins over software or service clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overflow_flag_zero <= 1'b0;
        end else if (set0) begin
            overflow_flag_zero <= 1'b1;
        end else if (wr_ctl) begin
            overflow_flag_zero <= wbyte[`DTC_CTL_FLAG_ZERO];
        end else if (int_serviced_zero) begin
            overflow_flag_zero <= 1'b0;
        end
    end

    // Flag one follows the split high byte while timer 0 is split
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overflow_flag_one <= 1'b0;
        end else if (set1) begin
            overflow_flag_one <= 1'b1;
        end else if (wr_ctl) begin
            overflow_flag_one <= wbyte[`DTC_CTL_FLAG_ONE];
        end else if (int_serviced_one) begin
            overflow_flag_one <= 1'b0;
        end
    end

    // Timer 1 overflow pulse for the serial baud generator
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baud_q <= 1'b0;
        end else begin
            baud_q <= ovf1;
        end
    end
    assign baud_tick = baud_q;

endmodule

// file: tb/dtc_timer_properties.sv
// Assertions on the timer's bus answers and flag outputs
`timescale 1ns/10ps
`include "dtc_defs.svh"
module dtc_timer_properties #(
    parameter int ADR_W = 12
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic int_serviced_zero,
    input wire logic int_serviced_one,
    input wire logic overflow_flag_zero,
    input wire logic overflow_flag_one,
    input wire logic baud_tick
);
    logic req;
    logic ctl_wr;
    // Pending request and control write landing
    assign req = wb_cyc_i & wb_stb_i;
    assign ctl_wr = req & wb_we_i & wb_ack_o & wb_sel_i[0]
        & (wb_adr_i[9:2] == `DTC_IDX_CONTROL);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ********************
    // Bus answers
    // ********************
    chk_ack_latency: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without a request");
    chk_read_upper: assert property (wb_ack_o |-> !(|wb_dat_o[31:8]))
        else $error("read data upper bits not zero");
    // ********************
    // Flags and baud tick
    // ********************
    chk_flag0_hold: assert property (overflow_flag_zero &&
        !int_serviced_zero && !ctl_wr |=> overflow_flag_zero)
        else $error("flag zero dropped without cause");
    chk_flag1_hold: assert property (overflow_flag_one &&
        !int_serviced_one && !ctl_wr |=> overflow_flag_one)
        else $error("flag one dropped without cause");
    chk_flag0_clear: assert property ($fell(overflow_flag_zero)
        |-> $past(int_serviced_zero || ctl_wr))
        else $error("flag zero cleared without service or write");
    chk_flag1_clear: assert property ($fell(overflow_flag_one)
        |-> $past(int_serviced_one || ctl_wr))
        else $error("flag one cleared without service or write");
    chk_baud_pulse: assert property (baud_tick |=> !baud_tick)
        else $error("baud tick longer than one cycle");
    cover property (ctl_wr);
    cover property (int_serviced_zero && overflow_flag_zero);
    cover property ($rose(baud_tick));
endmodule

// file: tb/dtc_pin_model.sv
// Model of the external count and gate pins
`timescale 1ns/10ps
module dtc_pin_model #(
    parameter int MC = 4
) (
    input wire logic clk,
    output logic count_input_zero,
    output logic count_input_one,
    output logic external_gate_pin_zero,
    output logic external_gate_pin_one
);
    // Set to steer pulses and gate levels to timer one's pins
    bit use_one;
    // Count lines idle high, gates open
    initial begin
        count_input_zero = 1'b1;
        count_input_one = 1'b1;
        external_gate_pin_zero = 1'b1;
        external_gate_pin_one = 1'b1;
    end
    // Falling edges, each level held two machine cycles
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            if (use_one)
                count_input_one <= 1'b0;
            else
                count_input_zero <= 1'b0;
            repeat (2 * MC) @(posedge clk);
            count_input_zero <= 1'b1;
            count_input_one <= 1'b1;
            repeat (2 * MC) @(posedge clk);
        end
    endtask
    // Gate level for the selected timer
    task automatic gate(input logic lvl);
        @(posedge clk);
        if (use_one)
            external_gate_pin_one <= lvl;
        else
            external_gate_pin_zero <= lvl;
    endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/10ps
module tb;
    localparam int MC = 4;
    localparam logic [7:0] CTL = 8'h88, MOD = 8'h89, LO0 = 8'h8A;
    localparam logic [7:0] LO1 = 8'h8B, HI0 = 8'h8C, HI1 = 8'h8D;
    logic clk, resetn;
    logic wb_cyc_i, wb_stb_i, wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i, lanes;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, count_input_zero, count_input_one;
    logic external_gate_pin_zero, external_gate_pin_one;
    logic int_serviced_zero, int_serviced_one;
    logic overflow_flag_zero, overflow_flag_one, baud_tick;
    logic [7:0] rd, snap;
    int fails = 0, tests_run = 0, cycles = 0;
    dtc_timer #(.MC_CLOCKS(MC)) uut (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .count_input_zero, .count_input_one, .external_gate_pin_zero,
        .external_gate_pin_one, .int_serviced_zero, .int_serviced_one,
        .overflow_flag_zero, .overflow_flag_one, .baud_tick);
    dtc_pin_model #(.MC(MC)) pm (.clk, .count_input_zero, .count_input_one,
        .external_gate_pin_zero, .external_gate_pin_one);
    // ********************
    // Clock, timeout, tasks
    // ********************
    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("unexpected timeout: expected end, seen hang");
            tally_and_finish();
        end
    end
    // One classic bus cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [7:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {2'b00, idx, 2'b00};
        wb_sel_i <= lanes;
        wb_dat_i <= {24'h00_0000, d};
        // Ends on ack; if ack never comes only the hang guard ends this wait
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp,
                         input string what);
        wb(1'b0, idx, 8'h00);
        chk(what, exp, rd);
    endtask
    // Stop both, load timer zero counts, then mode
    task automatic load(input logic [7:0] m, lo, hi);
        wb(1'b1, CTL, 8'h00);
        wb(1'b1, LO0, lo);
        wb(1'b1, HI0, hi);
        wb(1'b1, MOD, m);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_regs();
        rdchk(CTL, 8'h00, "control reset");
        rdchk(MOD, 8'h00, "mode reset");
        for (int i = 8'h8A; i <= 8'h8D; i++)
            rdchk(8'(i), 8'h00, "count reset");
        rdchk(8'h8F, 8'h00, "unmapped");
        wb(1'b1, MOD, 8'hA5);
        rdchk(MOD, 8'hA5, "mode readback");
        wb(1'b1, CTL, 8'hAF);
        rdchk(CTL, 8'hA0, "control readback");
        chk("flag one pin", 8'h01, {7'h00, overflow_flag_one});
        wb(1'b1, LO1, 8'h3C);
        rdchk(LO1, 8'h3C, "low one");
        lanes = 4'hE;
        wb(1'b1, LO1, 8'h55);
        lanes = 4'h1;
        rdchk(LO1, 8'h3C, "lane zero off");
        $display("test regs done");
    endtask
    task automatic t_modes();
        load(8'h05, 8'hFD, 8'hFF);
        wb(1'b1, CTL, 8'h10);
        rdchk(LO0, 8'hFD, "count kept at run");
        pm.pulse(3);
        rdchk(LO0, 8'h00, "mode 1 low");
        rdchk(HI0, 8'h00, "mode 1 high");
        chk("flag zero", 8'h01, {7'h00, overflow_flag_zero});
        load(8'h04, 8'hFE, 8'hFF);
        chk("flag zero cleared", 8'h00, {7'h00, overflow_flag_zero});
        wb(1'b1, CTL, 8'h10);
        pm.pulse(2);
        rdchk(LO0, 8'hE0, "mode 0 low");
        rdchk(HI0, 8'h00, "mode 0 high");
        chk("flag zero 13", 8'h01, {7'h00, overflow_flag_zero});
        load(8'h06, 8'hFF, 8'h80);
        wb(1'b1, CTL, 8'h10);
        pm.pulse(2);
        rdchk(LO0, 8'h81, "reload low");
        rdchk(HI0, 8'h80, "reload high");
        chk("flag reload", 8'h01, {7'h00, overflow_flag_zero});
        $display("test modes done");
    endtask
    task automatic t_gate();
        load(8'h0D, 8'h00, 8'h00);
        pm.gate(1'b0);
        wb(1'b1, CTL, 8'h10);
        pm.pulse(2);
        rdchk(LO0, 8'h00, "gate closed");
        pm.gate(1'b1);
        pm.pulse(2);
        rdchk(LO0, 8'h02, "gate open");
        wb(1'b1, CTL, 8'h00);
        pm.pulse(1);
        rdchk(LO0, 8'h02, "run clear");
        pm.gate(1'b0);
        wb(1'b1, MOD, 8'h05);
        wb(1'b1, CTL, 8'h10);
        pm.pulse(1);
        rdchk(LO0, 8'h03, "gate bit clear");
        pm.gate(1'b1);
        $display("test gate done");
    endtask
    task automatic t_timer();
        wb(1'b1, LO1, 8'h00);
        wb(1'b1, HI1, 8'h00);
        wb(1'b1, MOD, 8'h10);
        wb(1'b1, CTL, 8'h40);
        repeat (10 * MC) @(posedge clk);
        wb(1'b1, CTL, 8'h00);
        wb(1'b0, LO1, 8'h00);
        chk("ticks in window", 8'h01, {7'h00, rd >= 9 && rd <= 11});
        rdchk(HI1, 8'h00, "timer high");
        wb(1'b1, MOD, 8'h30);
        wb(1'b1, CTL, 8'h40);
        wb(1'b0, LO1, 8'h00);
        snap = rd;
        repeat (10 * MC) @(posedge clk);
        rdchk(LO1, snap, "mode 3 hold");
        $display("test timer done");
    endtask
    task automatic t_split();
        int n;
        wb(1'b1, LO1, 8'hFF);
        wb(1'b1, HI1, 8'hFF);
        load(8'h13, 8'h00, 8'hFF);
        n = 0;
        while (baud_tick !== 1'b1 && n < 3 * MC) begin
            @(posedge clk);
            n++;
        end
        chk("baud tick", 8'h01, {7'h00, baud_tick});
        chk("no flag one", 8'h00, {7'h00, overflow_flag_one});
        wb(1'b1, CTL, 8'h40);
        repeat (2 * MC) @(posedge clk);
        chk("split high flag", 8'h01, {7'h00, overflow_flag_one});
        rdchk(LO0, 8'h00, "split low idle");
        $display("test split done");
    endtask
    task automatic t_service();
        load(8'h05, 8'hFF, 8'hFF);
        wb(1'b1, CTL, 8'h90);
        pm.pulse(1);
        chk("flag zero set", 8'h01, {7'h00, overflow_flag_zero});
        @(posedge clk);
        int_serviced_zero <= 1'b1;
        int_serviced_one <= 1'b1;
        @(posedge clk);
        int_serviced_zero <= 1'b0;
        int_serviced_one <= 1'b0;
        @(posedge clk);
        chk("serviced zero", 8'h00, {7'h00, overflow_flag_zero});
        chk("serviced one", 8'h00, {7'h00, overflow_flag_one});
        $display("test service done");
    endtask
    task automatic t_count_one();
        pm.use_one = 1'b1;
        wb(1'b1, CTL, 8'h00);
        wb(1'b1, LO1, 8'h00);
        wb(1'b1, HI1, 8'h00);
        wb(1'b1, MOD, 8'hD0);
        pm.gate(1'b0);
        wb(1'b1, CTL, 8'h40);
        pm.pulse(2);
        rdchk(LO1, 8'h00, "gate one closed");
        pm.gate(1'b1);
        pm.pulse(2);
        rdchk(LO1, 8'h02, "count one");
        rdchk(LO0, 8'h00, "count zero still");
        pm.use_one = 1'b0;
        $display("test count one done");
    endtask
    // Reset, then the scenarios in turn
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        lanes = 4'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 7'h00;
        wb_adr_i = 12'h000;
        wb_dat_i = 32'h0000_0000;
        {int_serviced_zero, int_serviced_one} = 2'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_modes();
        t_gate();
        t_timer();
        t_split();
        t_service();
        t_count_one();
        tally_and_finish();
    end
endmodule
bind dtc_timer dtc_timer_properties #(.ADR_W(ADR_W)) chk_i (.clk, .resetn,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .int_serviced_zero, .int_serviced_one, .overflow_flag_zero,
    .overflow_flag_one, .baud_tick);
